/* design/fault_flag_pkg.sv */
// shared constants and carrier types for the charger flag block
package fault_flag_pkg;

	localparam int unsigned CLK_MHZ         = 100;
	// interrupt pulse length in microseconds
	localparam int unsigned INT_PULSE_US    = 128;
	localparam int unsigned INT_PULSE_CYC   = INT_PULSE_US * CLK_MHZ;
	localparam logic [13:0] INT_PULSE_LAST  = 14'(INT_PULSE_CYC - 1);
	localparam int unsigned NUM_FLAGS       = 10;

	// flag positions
	localparam int unsigned F_INPUT_GOOD    = 0;
	localparam int unsigned F_BAT_OCP       = 1;
	localparam int unsigned F_TS_COLD       = 2;
	localparam int unsigned F_TS_COOL       = 3;
	localparam int unsigned F_TS_HOT        = 4;
	localparam int unsigned F_WATCHDOG      = 5;
	localparam int unsigned F_TIMER_EXP     = 6;
	localparam int unsigned F_WAKE1         = 7;
	localparam int unsigned F_WAKE2         = 8;
	localparam int unsigned F_RESET_WARN    = 9;

	// system rail source values
	localparam logic [1:0] RAIL_SRC_INPUT   = 2'h0;
	// power-good output source values
	localparam logic [1:0] PG_SRC_INPUT     = 2'h0;
	localparam logic [1:0] PG_SRC_GPO       = 2'h1;
	localparam logic [1:0] PG_SRC_BUTTON    = 2'h2;

	localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = '0;

	typedef struct packed {
		logic input_good_status;
		logic bat_overcurrent;
		logic ts_cold;
		logic ts_cool;
		logic ts_hot;
		logic watchdog_expired;
		logic timer_expired;
		logic push_button_input;
		logic wake1_elapsed;
		logic wake2_elapsed;
		logic reset_warn_elapsed;
		logic die_overheat_shutdown;
		logic charge_enable;
	} cond_t;

	typedef struct packed {
		logic       charge_enable;
		logic       charge_reduced;
		logic       timer_run;
		logic       timer_reset;
		logic       timer_double;
		logic       rail_from_input;
		logic       rail_from_battery;
	} charger_ctrl_t;

	typedef enum logic {
		PULSE_IDLE,
		PULSE_LOW
	} pulse_state_t;

endpackage : fault_flag_pkg

/* design/int_pulse_gen.sv */
// open-drain interrupt pulse stretcher
`timescale 1ns/1ns
module int_pulse_gen
	import fault_flag_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// trigger
	input  wire logic trigger,
	// open-drain pin
	output logic      int_oe
);

	typedef struct packed {
		pulse_state_t st;
		logic [13:0]  cnt;
		logic         oe;
	} pulse_regs_t;

	pulse_regs_t s_reg;
	pulse_regs_t s_next;

	always_comb begin
		s_next = s_reg;
		case (s_reg.st)
			PULSE_IDLE: begin
				if (trigger) begin
					s_next.st  = PULSE_LOW;
					s_next.cnt = '0;
					s_next.oe  = 1'b1;
				end
			end
			PULSE_LOW: begin
				if (s_reg.cnt == INT_PULSE_LAST) begin
					s_next.st = PULSE_IDLE;
					s_next.oe = 1'b0;
				end else begin
					s_next.cnt = s_reg.cnt + 14'h1;
				end
			end
			default: begin
				s_next.st = PULSE_IDLE;
				s_next.oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_reg <= '{st: PULSE_IDLE, cnt: 14'h0, oe: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign int_oe = s_reg.oe;

endmodule : int_pulse_gen

/* design/charger_fault_flag_response.sv */
// charger fault flags, reaction logic and power-good pin select
//
// Behaviour
// - input-good change flag on both edges; low disables charge, resets timer.
// - overcurrent flag on rise; charging off, battery disconnected from rail.
// - cold or hot flag on rise; charge and timer paused meanwhile.
// - cool flag on rise; reduced current; timer doubled when option set.
// - watchdog flag on rise; charging and timer unaffected.
// - timer flag set on expiry; cleared only by input or enable toggle.
// - after timer fault charge off until toggle; timer restarts after clear.
// - three button flags on rising edges; no effect on charger or rail.
// - power-good pin active by default while input is good.
// - power-good pin selectable as host-written general purpose output.
// - power-good pin optionally follows the push-button level.
// - unmasked trigger pulls interrupt low for 128 us.
// - masked triggers never pulse, even after unmasking.
`timescale 1ns/1ns
module charger_fault_flag_response
	import fault_flag_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	// live conditions
	input  wire cond_t                cond,
	// host controls
	input  wire logic [NUM_FLAGS-1:0] flag_mask,
	input  wire logic [NUM_FLAGS-1:0] flag_clear,
	input  wire logic [1:0]           system_rail_source_select,
	input  wire logic                 timer_double_enable,
	input  wire logic [1:0]           power_good_source,
	input  wire logic                 power_good_gpo_level,
	// flags and reaction
	output logic [NUM_FLAGS-1:0]      flags,
	output charger_ctrl_t             ctrl,
	// open-drain pins, enable high pulls low
	output logic                      power_good_output_oe,
	output logic                      int_oe
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		cond_t                prev;
		logic [NUM_FLAGS-1:0] flags;
		charger_ctrl_t        ctrl;
		logic                 pg_oe;
		logic                 irq;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [NUM_FLAGS-1:0] trig;
	logic                 in_toggle;
	logic                 ce_toggle;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next      = s_reg;
		s_next.prev = cond;
		in_toggle   = cond.input_good_status != s_reg.prev.input_good_status;
		ce_toggle   = cond.charge_enable != s_reg.prev.charge_enable;
		trig        = '0;
		trig[F_INPUT_GOOD] = in_toggle;
		trig[F_BAT_OCP] = cond.bat_overcurrent &
			~s_reg.prev.bat_overcurrent;
		trig[F_TS_COLD] = cond.ts_cold & ~s_reg.prev.ts_cold;
		trig[F_TS_HOT]  = cond.ts_hot & ~s_reg.prev.ts_hot;
		trig[F_TS_COOL] = cond.ts_cool & ~s_reg.prev.ts_cool;
		trig[F_WATCHDOG] = cond.watchdog_expired &
			~s_reg.prev.watchdog_expired;
		trig[F_TIMER_EXP] = cond.timer_expired & ~s_reg.prev.timer_expired;
		trig[F_WAKE1] = cond.wake1_elapsed & ~s_reg.prev.wake1_elapsed;
		trig[F_WAKE2] = cond.wake2_elapsed & ~s_reg.prev.wake2_elapsed;
		trig[F_RESET_WARN] = cond.reset_warn_elapsed &
			~s_reg.prev.reset_warn_elapsed;

		// set wins over clear
		s_next.flags = (s_reg.flags & ~flag_clear) | trig;
		// timer flag cleared only by toggle
		s_next.flags[F_TIMER_EXP] = trig[F_TIMER_EXP] |
			(s_reg.flags[F_TIMER_EXP] & ~(in_toggle | ce_toggle));

		s_next.irq = |(trig & ~flag_mask);

		// charger reaction
		s_next.ctrl.charge_enable = cond.charge_enable &
			cond.input_good_status;
		s_next.ctrl.timer_run     = s_next.ctrl.charge_enable;
		s_next.ctrl.timer_reset   = 1'b0;
		if (!cond.input_good_status) begin
			s_next.ctrl.timer_reset = 1'b1;
		end
		if (cond.bat_overcurrent) begin
			s_next.ctrl.charge_enable = 1'b0;
			s_next.ctrl.timer_run     = 1'b0;
		end
		if (cond.ts_cold | cond.ts_hot) begin
			s_next.ctrl.charge_enable = 1'b0;
			s_next.ctrl.timer_run     = 1'b0;
		end
		// held off until toggle clears flag
		if (s_next.flags[F_TIMER_EXP]) begin
			s_next.ctrl.charge_enable = 1'b0;
			s_next.ctrl.timer_run     = 1'b0;
		end
		if (s_reg.flags[F_TIMER_EXP] & ~s_next.flags[F_TIMER_EXP]) begin
			s_next.ctrl.timer_reset = 1'b1;
		end
		s_next.ctrl.charge_reduced = cond.ts_cool;
		s_next.ctrl.timer_double   = cond.ts_cool & timer_double_enable;

		// rail from input only with source 00
		s_next.ctrl.rail_from_input = cond.input_good_status &
			(system_rail_source_select == RAIL_SRC_INPUT);
		s_next.ctrl.rail_from_battery = ~cond.bat_overcurrent;

		if (cond.die_overheat_shutdown) begin
			s_next.ctrl.charge_enable     = 1'b0;
			s_next.ctrl.timer_run         = 1'b0;
			s_next.ctrl.rail_from_input   = 1'b0;
			s_next.ctrl.rail_from_battery = 1'b0;
		end

		// power-good pin source, active means pulled low
		case (power_good_source)
			PG_SRC_INPUT:  s_next.pg_oe = cond.input_good_status;
			PG_SRC_GPO:    s_next.pg_oe = ~power_good_gpo_level;
			PG_SRC_BUTTON: s_next.pg_oe = ~cond.push_button_input;
			default:       s_next.pg_oe = cond.input_good_status;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	int_pulse_gen u_pulse (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.trigger (s_reg.irq),
		.int_oe  (int_oe)
	);

	assign flags                = s_reg.flags;
	assign ctrl                 = s_reg.ctrl;
	assign power_good_output_oe = s_reg.pg_oe;

endmodule : charger_fault_flag_response

/* bench/host_model.sv */
// host side model of the interrupt pin and output write
`timescale 1ns/1ns
module host_model (
	// pins
	input  wire logic ref_clk,
	input  wire logic int_oe,
	// host requests and view
	input  wire logic gpo_want,
	output logic      gpo_level,
	output int        n_pulse
);
	wire  int_pin = int_oe ? 1'b0 : 1'b1;
	logic pin_prev = 1'b1;
	initial n_pulse = 0;
	initial gpo_level = 1'b1;
	always @(posedge ref_clk) begin
		gpo_level <= gpo_want;
		if (pin_prev && !int_pin) n_pulse++;
		pin_prev = int_pin;
	end
endmodule // host_model

/* bench/charger_flag_checker.sv */
// port assertions for the charger flag block
`timescale 1ns/1ns
module charger_flag_checker
	import fault_flag_pkg::*;
(
	// clock and reset
	input wire logic                 ref_clk,
	input wire logic                 rstn,
	// watched ports
	input wire cond_t                cond,
	input wire logic [1:0]           power_good_source,
	input wire logic                 power_good_gpo_level,
	input wire logic [NUM_FLAGS-1:0] flags,
	input wire charger_ctrl_t        ctrl,
	input wire logic                 power_good_output_oe,
	input wire logic                 int_oe
);
	logic [13:0] hi_cnt;
	always_ff @(posedge ref_clk) begin
		hi_cnt <= (!rstn || !int_oe) ? 14'h0 : hi_cnt + 14'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	ig_flag_a: assert property ($past(rstn) &&
		$changed(cond.input_good_status) |=> flags[F_INPUT_GOOD])
		else $error("input flag missing");
	ig_chg_a: assert property (!cond.input_good_status
		|=> !ctrl.charge_enable) else $error("charge on without input");
	bat_ocp_a: assert property ($past(rstn) &&
		$rose(cond.bat_overcurrent) |=> flags[F_BAT_OCP] &&
		!ctrl.charge_enable && !ctrl.rail_from_battery)
		else $error("overcurrent response");
	ts_pause_a: assert property (cond.ts_hot || cond.ts_cold
		|=> !ctrl.charge_enable && !ctrl.timer_run)
		else $error("charge not paused");
	tmr_hold_a: assert property (flags[F_TIMER_EXP] &&
		$stable(cond.input_good_status) && $stable(cond.charge_enable)
		|=> flags[F_TIMER_EXP]) else $error("timer flag lost");
	overheat_off_a: assert property (cond.die_overheat_shutdown
		|=> !ctrl.charge_enable && !ctrl.timer_run &&
		!ctrl.rail_from_input && !ctrl.rail_from_battery)
		else $error("overheat response");
	pg_in_a: assert property (power_good_source == PG_SRC_INPUT
		|=> power_good_output_oe == $past(cond.input_good_status))
		else $error("pg input source");
	pg_gpo_a: assert property (power_good_source == PG_SRC_GPO
		|=> power_good_output_oe == !$past(power_good_gpo_level))
		else $error("pg gpo source");
	pg_btn_a: assert property (power_good_source == PG_SRC_BUTTON
		|=> power_good_output_oe == !$past(cond.push_button_input))
		else $error("pg button source");
	int_len_a: assert property ($fell(int_oe)
		|-> hi_cnt == 14'(INT_PULSE_CYC)) else $error("pulse length");
	cover property (int_oe [*2]);
	cover property ($rose(flags[F_TIMER_EXP]));
	cover property (cond.die_overheat_shutdown);
endmodule // charger_flag_checker
bind charger_fault_flag_response charger_flag_checker chk_u (.ref_clk,
	.rstn, .cond, .power_good_source, .power_good_gpo_level, .flags,
	.ctrl, .power_good_output_oe, .int_oe);

/* bench/test_charger_fault_flag_response.sv */
// self-checking bench for the charger flag block
`timescale 1ns/1ns
module test_charger_fault_flag_response;
	import fault_flag_pkg::*;
	logic          ref_clk = 0;
	logic          rstn = 0;
	cond_t         cond = '0;
	logic [9:0]    mask = '1;
	logic [9:0]    clr = '0;
	logic [1:0]    src = 2'h0;
	logic [1:0]    rail_sel = 2'h0;
	logic          tdbl = 1'b1;
	logic          gpo_want = 1;
	logic          gpo;
	logic [9:0]    flags;
	logic [9:0]    f;
	charger_ctrl_t ctrl;
	logic          pg_oe;
	logic          int_oe;
	int            n_pulse;
	int            n_mismatch = 0;
	int            num_checks = 0;
	charger_fault_flag_response dut_u (.ref_clk, .rstn, .cond,
		.flag_mask(mask), .flag_clear(clr),
		.system_rail_source_select(rail_sel),
		.timer_double_enable(tdbl), .power_good_source(src),
		.power_good_gpo_level(gpo), .flags, .ctrl,
		.power_good_output_oe(pg_oe), .int_oe);
	host_model host_u (.ref_clk, .int_oe, .gpo_want, .gpo_level(gpo),
		.n_pulse);
	always #5 ref_clk = ~ref_clk;
	task chk(string n, logic [15:0] s, logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task step(int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task print_verdict;
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#600000;
		n_mismatch++;
		print_verdict;
	end
	initial begin
		step(8);
		rstn = 1;
		cond.input_good_status = 1;
		cond.charge_enable = 1;
		step(2);
		chk("flags", flags, 10'h001);
		mask = '0;
		step(20);
		chk("int", int_oe, 0);
		chk("pg", pg_oe, 1);
		cond.bat_overcurrent = 1;
		step(1);
		chk("flags", flags, 10'h003);
		chk("chg", ctrl.charge_enable, 0);
		step(2);
		chk("int", int_oe, 1);
		cond.watchdog_expired = 1;
		step(12798);
		chk("int", int_oe, 1);
		step(1);
		chk("int", int_oe, 0);
		chk("flags", flags, 10'h023);
		chk("pulses", n_pulse, 1);
		clr = '1;
		cond.bat_overcurrent = 0;
		cond.timer_expired = 1;
		step(1);
		clr = '0;
		step(1);
		chk("flags", flags, 10'h040);
		chk("chg", ctrl.charge_enable, 0);
		cond.timer_expired = 0;
		cond.charge_enable = 0;
		step(1);
		chk("treset", ctrl.timer_reset, 1);
		step(1);
		chk("treset", ctrl.timer_reset, 0);
		cond.charge_enable = 1;
		step(2);
		chk("tflag", flags[F_TIMER_EXP], 0);
		chk("chg", ctrl.charge_enable, 1);
		cond.ts_hot = 1;
		step(1);
		chk("hot", {flags[F_TS_HOT], ctrl.charge_enable}, 2'h2);
		cond.ts_hot = 0;
		cond.wake1_elapsed = 1;
		cond.wake2_elapsed = 1;
		cond.reset_warn_elapsed = 1;
		step(2);
		chk("btn", flags[9:7], 3'h7);
		chk("chg", ctrl.charge_enable, 1);
		f = flags;
		cond.die_overheat_shutdown = 1;
		step(2);
		chk("off", {ctrl.charge_enable, ctrl.timer_run, ctrl.rail_from_input,
			ctrl.rail_from_battery}, 4'h0);
		chk("flags", flags, f);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 3; i++) begin
				src = 2'(i);
				gpo_want = !p;
				cond.push_button_input = p[0];
				step(3);
				chk("pg", pg_oe, i == 0 ? 1 : (i == 1 ? p : !p));
			end
		end
		cond.die_overheat_shutdown = 0;
		cond.ts_cool = 1;
		step(2);
		chk("cool", flags[F_TS_COOL], 1);
		chk("cool", {ctrl.charge_enable, ctrl.charge_reduced,
			ctrl.timer_double, ctrl.rail_from_input}, 4'hF);
		tdbl = 0;
		rail_sel = 2'h1;
		step(2);
		chk("cool", {ctrl.timer_double, ctrl.rail_from_input}, 2'h0);
		print_verdict;
	end
endmodule // test_charger_fault_flag_response
